// [hdl/swc_nv_mem.sv]
// Configuration byte store with a registered read port and taps for the block.
`timescale 1ns/100ps
module swc_nv_mem #(
	parameter int unsigned DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_r,
	output logic [7:0] sleep_high,
	output logic [7:0] sleep_low,
	output logic [7:0] wait_slots,
	output logic [7:0] pin_mask
);
	logic [7:0] mem_r [DEPTH];
	logic [7:0] mem_nxt [DEPTH];
	logic [7:0] rdata_nxt;

	// The reset image stands in for the stored power-up contents.
	function automatic logic [7:0] image(input int unsigned i);
		if (i == int'(swc_pkg::ADDR_SLEEP_HIGH)) begin
			image = swc_pkg::RST_SLEEP_HIGH;
		end else if (i == int'(swc_pkg::ADDR_SLEEP_LOW)) begin
			image = swc_pkg::RST_SLEEP_LOW;
		end else if (i == int'(swc_pkg::ADDR_WAIT_SLOTS)) begin
			image = swc_pkg::RST_WAIT_SLOTS;
		end else if (i == int'(swc_pkg::ADDR_PIN_MASK)) begin
			image = swc_pkg::RST_PIN_MASK;
		end else begin
			image = 8'h00;
		end
	endfunction : image

	always_comb begin
		mem_nxt = mem_r;
		rdata_nxt = rdata_r;
		if (wr_en && int'(addr) < DEPTH) begin
			mem_nxt[addr] = wdata;
		end
		if (rd_en) begin
			rdata_nxt = (int'(addr) < DEPTH) ? mem_r[addr] : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_r[i] <= reset ? image(i) : mem_nxt[i];
		end
		rdata_r <= reset ? 8'h00 : rdata_nxt;
	end

	assign sleep_high = mem_r[swc_pkg::ADDR_SLEEP_HIGH];
	assign sleep_low = mem_r[swc_pkg::ADDR_SLEEP_LOW];
	assign wait_slots = mem_r[swc_pkg::ADDR_WAIT_SLOTS];
	assign pin_mask = mem_r[swc_pkg::ADDR_PIN_MASK];
endmodule : swc_nv_mem

// [hdl/swc_pin_watch.sv]
// Recorded pin levels and masked change detection for the watched pins.
`timescale 1ns/100ps
module swc_pin_watch (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] pins,
	input wire logic [7:0] enable,
	input wire logic capture,
	input wire logic update,
	output logic [7:0] changed
);
	logic [7:0] recorded_r;
	logic [7:0] recorded_nxt;

	always_comb begin
		recorded_nxt = recorded_r;
		if (capture || update) begin
			recorded_nxt = pins;
		end
	end

	always_ff @(posedge clk) begin
		recorded_r <= reset ? 8'h00 : recorded_nxt;
	end

	assign changed = (pins ^ recorded_r) & enable;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_RECORD_AFTER_REPORT: assert property (update |=> (changed & $past(enable) & ~(pins ^ $past(pins))) == 8'h00)
		else $error("Reported change still flagged after update.");
endmodule : swc_pin_watch

// [hdl/swc_pkg.sv]
// Constants, types and helpers shared by the sleep and wake controller.
// Function
// - Low strap at power up: record pins, sleep.
// - Asleep: radio hibernates, processor stopped.
// - Location 8 mask enables pin watching.
// - Mask bits map to pins per variant.
// - Watched input change wakes, sends 0xC1.
// - Locations 4 and 5 form sleep duration.
// - Timer expiry wakes, broadcasts 0xC2 packet.
// - No reply in wait time: sleep again.
// - Command 0xA4 returns device to sleep.
// - Location 6 counts half-second send slots.
// - Low reserved strap selects reserved mode.
// - Pin packet carries levels and changed bits.
// - Timed packet carries no data bytes.
package swc_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SLOT_MS = 500;
	localparam int unsigned SLEEP_UNIT_S = 5;
	// Counts of clock cycles derived from the times above.
	localparam int unsigned SLOT_CYCLES = SLOT_MS * (CLK_HZ / 1000);
	localparam int unsigned SLEEP_UNIT_CYCLES = SLEEP_UNIT_S * CLK_HZ;

	localparam logic [3:0] ADDR_SLEEP_HIGH = 4'h4;
	localparam logic [3:0] ADDR_SLEEP_LOW = 4'h5;
	localparam logic [3:0] ADDR_WAIT_SLOTS = 4'h6;
	localparam logic [3:0] ADDR_PIN_MASK = 4'h8;

	localparam logic [7:0] RST_SLEEP_HIGH = 8'h00;
	localparam logic [7:0] RST_SLEEP_LOW = 8'h01;
	localparam logic [7:0] RST_WAIT_SLOTS = 8'h01;
	localparam logic [7:0] RST_PIN_MASK = 8'h00;

	localparam logic [7:0] CMD_PIN_CHECKIN = 8'hc1;
	localparam logic [7:0] CMD_TIMED_CHECKIN = 8'hc2;
	localparam logic [7:0] CMD_GO_SLEEP = 8'ha4;
	localparam logic [15:0] BCAST_DEST = 16'h0000;
	localparam logic [1:0] LEN_PIN = 2'h2;
	localparam logic [1:0] LEN_TIMED = 2'h0;

	// Watch mask bit positions whose pin differs between variants.
	localparam int unsigned BIT_ALT_HI = 5;
	localparam int unsigned BIT_ALT_LO = 4;

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_SLEEP,
		ST_RUN,
		ST_SEND,
		ST_WAIT,
		ST_RESERVED
	} swc_state_t;

	// A zero count is raised to one, the same single unit that the expiry test already gives a zero.
	function automatic logic [15:0] at_least_one(input logic [15:0] v);
		at_least_one = (v == 16'h0000) ? 16'h0001 : v;
	endfunction : at_least_one

endpackage : swc_pkg

// [hdl/swc_top.sv]
// Sleep and wake controller: strap sampling, timed and pin wake, check-in and wait slots.
`timescale 1ns/100ps
module swc_top #(
	parameter bit LATE_VARIANT = 1'b1,
	parameter int unsigned SLOT_CYCLES = swc_pkg::SLOT_CYCLES,
	parameter int unsigned SLEEP_UNIT_CYCLES = swc_pkg::SLEEP_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic low_power_strap_pin,
	input wire logic reserved_mode_strap_pin,
	input wire logic watch_pin_seven,
	input wire logic [6:0] port_b_pins,
	input wire logic [2:1] port_a_pins,
	input wire logic [7:0] pin_is_input,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic rx_valid,
	input wire logic [7:0] rx_cmd,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_cmd,
	output logic [15:0] tx_dest,
	output logic [1:0] tx_len,
	output logic [7:0] tx_data0,
	output logic [7:0] tx_data1,
	output logic radio_hibernate,
	output logic cpu_stop,
	output logic reserved_mode
);
	swc_pkg::swc_state_t state_r, state_nxt;
	logic [31:0] prescale_r, prescale_nxt;
	logic [15:0] units_r, units_nxt;
	logic [7:0] slots_r, slots_nxt;
	logic tx_valid_r, tx_valid_nxt;
	logic [7:0] tx_cmd_r, tx_cmd_nxt;
	logic [15:0] tx_dest_r, tx_dest_nxt;
	logic [1:0] tx_len_r, tx_len_nxt;
	logic [7:0] tx_data0_r, tx_data0_nxt;
	logic [7:0] tx_data1_r, tx_data1_nxt;
	logic hibernate_r, stop_r, reserved_r, reserved_nxt;
	logic capture, update;
	logic [7:0] sleep_high, sleep_low, wait_slots, pin_mask;
	logic [7:0] watch_pins, changed;
	logic change_any, unit_tick, slot_tick, go_sleep_cmd;
	logic [15:0] sleep_units;
	logic [15:0] wait_units;

	swc_nv_mem #(
		.DEPTH(16)
	) u_nv (
		.clk(clk),
		.reset(reset),
		.wr_en(cfg_wr),
		.rd_en(cfg_rd),
		.addr(cfg_addr),
		.wdata(cfg_wdata),
		.rdata_r(cfg_rdata),
		.sleep_high(sleep_high),
		.sleep_low(sleep_low),
		.wait_slots(wait_slots),
		.pin_mask(pin_mask)
	);

	// Mask bit order: A6, B6, then A2 and A1 on the later variant or B5 and B4 on the earlier one, then B3 to B0.
	always_comb begin
		watch_pins = {watch_pin_seven, port_b_pins[6], port_a_pins[2], port_a_pins[1], port_b_pins[3:0]};
		if (!LATE_VARIANT) begin
			watch_pins[swc_pkg::BIT_ALT_HI] = port_b_pins[5];
			watch_pins[swc_pkg::BIT_ALT_LO] = port_b_pins[4];
		end
	end

	// Pins driven as outputs never wake the block, whatever the mask says.
	swc_pin_watch u_watch (
		.clk(clk),
		.reset(reset),
		.pins(watch_pins),
		.enable(pin_mask & pin_is_input),
		.capture(capture),
		.update(update),
		.changed(changed)
	);

	assign change_any = |changed;
	assign sleep_units = swc_pkg::at_least_one({sleep_high, sleep_low});
	// A function result cannot be part-selected, so the widened slot count is kept as a net.
	assign wait_units = swc_pkg::at_least_one({8'h00, wait_slots});
	// One counter serves both the sleep unit and the wait slot, since the block never needs both at once.
	assign unit_tick = prescale_r == 32'(SLEEP_UNIT_CYCLES - 1);
	assign slot_tick = prescale_r == 32'(SLOT_CYCLES - 1);
	assign go_sleep_cmd = rx_valid && rx_cmd == swc_pkg::CMD_GO_SLEEP;

	always_comb begin
		state_nxt = state_r;
		prescale_nxt = 32'h00000000;
		units_nxt = units_r;
		slots_nxt = slots_r;
		tx_valid_nxt = tx_valid_r;
		tx_cmd_nxt = tx_cmd_r;
		tx_dest_nxt = tx_dest_r;
		tx_len_nxt = tx_len_r;
		tx_data0_nxt = tx_data0_r;
		tx_data1_nxt = tx_data1_r;
		reserved_nxt = reserved_r;
		capture = 1'b0;
		update = 1'b0;
		case (state_r)
			swc_pkg::ST_BOOT: begin
				capture = 1'b1;
				// The reserved strap is tested first, so its low level wins over the low-power strap.
				if (!reserved_mode_strap_pin) begin
					reserved_nxt = 1'b1;
					state_nxt = swc_pkg::ST_RESERVED;
				end else if (!low_power_strap_pin) begin
					state_nxt = swc_pkg::ST_SLEEP;
					units_nxt = sleep_units;
				end else begin
					state_nxt = swc_pkg::ST_RUN;
				end
			end
			swc_pkg::ST_SLEEP, swc_pkg::ST_RUN: begin
				// Commands are not heard while asleep, since the radio is hibernating.
				if (state_r == swc_pkg::ST_RUN && go_sleep_cmd) begin
					state_nxt = swc_pkg::ST_SLEEP;
					units_nxt = sleep_units;
				end else if (change_any) begin
					// The report snapshots levels and changed bits on the same edge that moves the record on.
					state_nxt = swc_pkg::ST_SEND;
					update = 1'b1;
					slots_nxt = wait_units[7:0];
					tx_valid_nxt = 1'b1;
					tx_cmd_nxt = swc_pkg::CMD_PIN_CHECKIN;
					tx_dest_nxt = swc_pkg::BCAST_DEST;
					tx_len_nxt = swc_pkg::LEN_PIN;
					tx_data0_nxt = watch_pins & pin_mask;
					tx_data1_nxt = changed;
				end else if (state_r == swc_pkg::ST_SLEEP) begin
					prescale_nxt = unit_tick ? 32'h00000000 : prescale_r + 32'h00000001;
					if (unit_tick && units_r <= 16'h0001) begin
						state_nxt = swc_pkg::ST_SEND;
						slots_nxt = wait_units[7:0];
						tx_valid_nxt = 1'b1;
						tx_cmd_nxt = swc_pkg::CMD_TIMED_CHECKIN;
						tx_dest_nxt = swc_pkg::BCAST_DEST;
						tx_len_nxt = swc_pkg::LEN_TIMED;
						tx_data0_nxt = 8'h00;
						tx_data1_nxt = 8'h00;
					end else if (unit_tick) begin
						units_nxt = units_r - 16'h0001;
					end
				end
			end
			swc_pkg::ST_SEND: begin
				if (tx_ready) begin
					tx_valid_nxt = 1'b0;
					state_nxt = swc_pkg::ST_WAIT;
				end
			end
			swc_pkg::ST_WAIT: begin
				prescale_nxt = prescale_r + 32'h00000001;
				// The slot count must not leak into the sleep count, or the first sleep unit would be cut short.
				if (go_sleep_cmd) begin
					state_nxt = swc_pkg::ST_SLEEP;
					units_nxt = sleep_units;
					prescale_nxt = 32'h00000000;
				end else if (rx_valid) begin
					// Any other reply opens a session that lasts until the go-to-sleep command or an unanswered pin check-in.
					state_nxt = swc_pkg::ST_RUN;
				end else if (slot_tick && slots_r <= 8'h01) begin
					state_nxt = swc_pkg::ST_SLEEP;
					units_nxt = sleep_units;
					prescale_nxt = 32'h00000000;
				end else if (slot_tick) begin
					slots_nxt = slots_r - 8'h01;
					tx_valid_nxt = 1'b1;
					state_nxt = swc_pkg::ST_SEND;
				end
			end
			swc_pkg::ST_RESERVED: begin
				// Only a reset leaves this mode; the block does nothing else while parked here.
				state_nxt = swc_pkg::ST_RESERVED;
			end
			default: begin
				state_nxt = swc_pkg::ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= swc_pkg::ST_BOOT;
			prescale_r <= 32'h00000000;
			units_r <= 16'h0000;
			slots_r <= 8'h00;
			tx_valid_r <= 1'b0;
			tx_cmd_r <= 8'h00;
			tx_dest_r <= swc_pkg::BCAST_DEST;
			tx_len_r <= 2'h0;
			tx_data0_r <= 8'h00;
			tx_data1_r <= 8'h00;
			hibernate_r <= 1'b0;
			stop_r <= 1'b0;
			reserved_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			prescale_r <= prescale_nxt;
			units_r <= units_nxt;
			slots_r <= slots_nxt;
			tx_valid_r <= tx_valid_nxt;
			tx_cmd_r <= tx_cmd_nxt;
			tx_dest_r <= tx_dest_nxt;
			tx_len_r <= tx_len_nxt;
			tx_data0_r <= tx_data0_nxt;
			tx_data1_r <= tx_data1_nxt;
			// Both follow the next state so that they rise on the very edge that enters sleep.
			hibernate_r <= state_nxt == swc_pkg::ST_SLEEP;
			stop_r <= state_nxt == swc_pkg::ST_SLEEP;
			reserved_r <= reserved_nxt;
		end
	end

	assign tx_valid = tx_valid_r;
	assign tx_cmd = tx_cmd_r;
	assign tx_dest = tx_dest_r;
	assign tx_len = tx_len_r;
	assign tx_data0 = tx_data0_r;
	assign tx_data1 = tx_data1_r;
	assign radio_hibernate = hibernate_r;
	assign cpu_stop = stop_r;
	assign reserved_mode = reserved_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence seq_pin_wake;
		(state_r == swc_pkg::ST_SLEEP || state_r == swc_pkg::ST_RUN) && !go_sleep_cmd && change_any;
	endsequence

	sequence seq_pin_report;
		tx_valid_r && tx_cmd_r == swc_pkg::CMD_PIN_CHECKIN && tx_len_r == swc_pkg::LEN_PIN;
	endsequence

	sequence seq_last_slot_out;
		state_r == swc_pkg::ST_WAIT && slot_tick && slots_r == 8'h01 && !rx_valid;
	endsequence

	sequence seq_sleep_entry;
		state_r == swc_pkg::ST_SLEEP && $past(state_r) != swc_pkg::ST_SLEEP;
	endsequence

	AST_BOOT_TO_SLEEP: assert property (state_r == swc_pkg::ST_BOOT && reserved_mode_strap_pin
		&& !low_power_strap_pin |=> state_r == swc_pkg::ST_SLEEP ##0 radio_hibernate)
		else $error("Low-power strap did not put the block to sleep.");

	AST_BOOT_AWAKE: assert property (state_r == swc_pkg::ST_BOOT && reserved_mode_strap_pin
		&& low_power_strap_pin |=> state_r == swc_pkg::ST_RUN ##0 !radio_hibernate && !cpu_stop)
		else $error("High low-power strap did not leave the block awake.");

	AST_RESERVED_FIRST: assert property (state_r == swc_pkg::ST_BOOT && !reserved_mode_strap_pin
		|=> state_r == swc_pkg::ST_RESERVED ##0 reserved_mode && !radio_hibernate)
		else $error("Reserved strap did not win at boot.");

	AST_SLEEP_HOLD: assert property (state_r == swc_pkg::ST_SLEEP |-> radio_hibernate && cpu_stop)
		else $error("Radio or processor awake while asleep.");

	AST_QUIET_ASLEEP: assert property (radio_hibernate |-> !tx_valid_r)
		else $error("Packet offered while the radio hibernates.");

	AST_MASKED_QUIET: assert property (state_r == swc_pkg::ST_SLEEP && changed == 8'h00 && !unit_tick
		|=> state_r == swc_pkg::ST_SLEEP)
		else $error("Block woke with no watched change and no timer expiry.");

	AST_PIN_PACKET: assert property (seq_pin_wake |=> seq_pin_report ##0 tx_data1_r == $past(changed))
		else $error("Pin change did not raise a pin check-in packet.");

	AST_PIN_LEVELS: assert property ($rose(tx_valid_r) && tx_cmd_r == swc_pkg::CMD_PIN_CHECKIN
		|-> (($past(state_r) == swc_pkg::ST_WAIT) ? tx_data0_r == $past(tx_data0_r)
		: tx_data0_r == ($past(watch_pins) & $past(pin_mask))))
		else $error("Pin packet levels byte is wrong.");

	AST_CHANGED_BYTE: assert property (tx_valid_r && tx_cmd_r == swc_pkg::CMD_PIN_CHECKIN
		|-> tx_data1_r != 8'h00)
		else $error("Pin packet carries no changed bit.");

	AST_SEND_STABLE: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_cmd_r)
		&& $stable(tx_len_r) && $stable(tx_data0_r) && $stable(tx_data1_r))
		else $error("Packet changed before the radio took it.");

	AST_TIMED_PACKET: assert property (tx_valid_r && tx_cmd_r == swc_pkg::CMD_TIMED_CHECKIN
		|-> tx_len_r == swc_pkg::LEN_TIMED && tx_dest_r == swc_pkg::BCAST_DEST)
		else $error("Timed check-in not a bare broadcast.");

	AST_TIMER_WAKE: assert property (state_r == swc_pkg::ST_SLEEP && unit_tick && units_r == 16'h0001
		&& !change_any |=> tx_valid_r && tx_cmd_r == swc_pkg::CMD_TIMED_CHECKIN && !radio_hibernate)
		else $error("Sleep timer expiry did not wake the block.");

	AST_SLEEP_RESTART: assert property (seq_sleep_entry
		|-> prescale_r == 32'h00000000 && units_r == $past(sleep_units))
		else $error("Sleep did not restart its full duration.");

	AST_GIVE_UP: assert property (seq_last_slot_out |=> state_r == swc_pkg::ST_SLEEP)
		else $error("Block stayed awake after the last wait slot.");

	AST_RETRY_SLOT: assert property (state_r == swc_pkg::ST_WAIT && slot_tick && slots_r > 8'h01
		&& !rx_valid |=> tx_valid_r ##0 slots_r == $past(slots_r) - 8'h01)
		else $error("Wait slot expiry did not resend the check-in.");

	AST_SLEEP_CMD: assert property ((state_r == swc_pkg::ST_WAIT || state_r == swc_pkg::ST_RUN)
		&& go_sleep_cmd |=> state_r == swc_pkg::ST_SLEEP ##0 cpu_stop && radio_hibernate)
		else $error("Sleep command not obeyed at once.");

	AST_RESERVED_STAY: assert property (state_r == swc_pkg::ST_RESERVED
		|-> reserved_mode ##1 state_r == swc_pkg::ST_RESERVED)
		else $error("Reserved mode left or not flagged.");
endmodule : swc_top

// [verification/swc_remote_ctrl.sv]
// Behavioural remote controller that takes check-in packets and may answer them.
`timescale 1ns/100ps
module swc_remote_ctrl (
	input wire logic clk,
	input wire logic tx_valid,
	input wire logic reply_en,
	input wire logic [7:0] reply_cmd,
	input wire logic [3:0] ready_delay,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_cmd
);
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_cmd = 8'h5a;
		forever begin
			@(negedge clk);
			if (tx_valid === 1'b1) begin
				repeat (ready_delay) @(negedge clk);
				// Ready stays up through the rising edge that takes the packet.
				tx_ready = 1'b1;
				@(negedge clk);
				tx_ready = 1'b0;
				// This model is the only controller, so each packet it takes gets at most one answer.
				if (reply_en) begin
					repeat (4) @(negedge clk);
					rx_valid = 1'b1;
					rx_cmd = reply_cmd;
					@(negedge clk);
					rx_valid = 1'b0;
					// A stale byte would hide a design that samples outside the pulse.
					rx_cmd = ~reply_cmd;
				end
			end
		end
	end
endmodule : swc_remote_ctrl

// [verification/tb_sleep_wake_controller.sv]
// Self-checking bench for the sleep and wake controller against a remote controller model.
`timescale 1ns/100ps
module tb_sleep_wake_controller;
	localparam int unsigned SLOT = 20;
	localparam int unsigned UNIT = 30;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic low_power_strap_pin = 1'b0;
	logic reserved_mode_strap_pin = 1'b1;
	logic watch_pin_seven = 1'b0;
	logic [6:0] port_b_pins = 7'h00;
	logic [2:1] port_a_pins = 2'h0;
	logic [7:0] pin_is_input = 8'hff;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [3:0] cfg_addr = 4'h0;
	logic [7:0] cfg_wdata = 8'h00;
	logic [7:0] cfg_rdata, rx_cmd, tx_cmd, tx_data0, tx_data1;
	logic rx_valid, tx_ready, tx_valid, radio_hibernate, cpu_stop, reserved_mode;
	logic [15:0] tx_dest;
	logic [1:0] tx_len;
	logic reply_en = 1'b0;
	logic [7:0] reply_cmd = 8'ha4;
	logic [3:0] ready_delay = 4'h0;
	int err_count = 0;
	int tests_run = 0;
	int pkt_count = 0;
	int n;
	int p;

	initial begin
		forever #5 clk = ~clk;
	end

	swc_top #(.LATE_VARIANT(1'b1), .SLOT_CYCLES(SLOT), .SLEEP_UNIT_CYCLES(UNIT)) dut (.clk, .reset,
		.low_power_strap_pin, .reserved_mode_strap_pin, .watch_pin_seven, .port_b_pins, .port_a_pins,
		.pin_is_input, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .rx_valid, .rx_cmd, .tx_ready,
		.tx_valid, .tx_cmd, .tx_dest, .tx_len, .tx_data0, .tx_data1, .radio_hibernate, .cpu_stop,
		.reserved_mode);

	swc_remote_ctrl partner (.clk, .tx_valid, .reply_en, .reply_cmd, .ready_delay, .tx_ready, .rx_valid,
		.rx_cmd);

	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			pkt_count <= pkt_count + 1;
		end
	end

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic cfg_write(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask : cfg_write

	task automatic cfg_check(input logic [3:0] a, input logic [7:0] exp);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		@(negedge clk);
		check("cfg_rdata", 16'(exp), 16'(cfg_rdata));
	endtask : cfg_check

	// Select 0 waits for tx_valid, select 1 for radio_hibernate; cnt returns the cycles spent.
	task automatic wait_for(input bit sel, input int lim, output int cnt);
		cnt = 0;
		while ((sel ? radio_hibernate : tx_valid) !== 1'b1 && cnt < lim) begin
			@(negedge clk);
			cnt++;
		end
		check(sel ? "radio_hibernate" : "tx_valid", 16'h0001, 16'(sel ? radio_hibernate : tx_valid));
	endtask : wait_for

	task automatic no_tx(input int k);
		int seen;
		seen = 0;
		repeat (k) begin
			@(negedge clk);
			seen |= (tx_valid !== 1'b0);
		end
		check("no_tx", 16'h0000, 16'(seen));
	endtask : no_tx

	task automatic chk_pkt(input logic [7:0] cmd, input logic [1:0] len, input logic [7:0] d0,
		input logic [7:0] d1);
		check("tx_cmd", 16'(cmd), 16'(tx_cmd));
		check("tx_dest", 16'h0000, tx_dest);
		check("tx_len", 16'(len), 16'(tx_len));
		check("tx_data0", 16'(d0), 16'(tx_data0));
		check("tx_data1", 16'(d1), 16'(tx_data1));
		check("asleep", 16'h0000, 16'({radio_hibernate, cpu_stop}));
	endtask : chk_pkt

	initial begin
		#300000;
		err_count++;
		$display("mismatch watchdog expected done seen hang");
		finish_test();
	end

	initial begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		check("radio_hibernate", 16'h0001, 16'(radio_hibernate));
		check("cpu_stop", 16'h0001, 16'(cpu_stop));
		check("reserved_mode", 16'h0000, 16'(reserved_mode));
		cfg_check(swc_pkg::ADDR_SLEEP_HIGH, 8'h00);
		cfg_check(swc_pkg::ADDR_SLEEP_LOW, 8'h01);
		cfg_check(swc_pkg::ADDR_WAIT_SLOTS, 8'h01);
		cfg_check(swc_pkg::ADDR_PIN_MASK, 8'h00);
		$display("test reset_image done");

		cfg_write(swc_pkg::ADDR_SLEEP_LOW, 8'h02);
		cfg_write(swc_pkg::ADDR_WAIT_SLOTS, 8'h02);
		cfg_check(swc_pkg::ADDR_WAIT_SLOTS, 8'h02);
		ready_delay = 4'h3;
		wait_for(0, 200, n);
		wait_for(1, 200, n);
		wait_for(0, 200, n);
		check("sleep_span", 16'h0001, 16'(n >= 2 * UNIT - 3 && n <= 2 * UNIT + 3));
		chk_pkt(swc_pkg::CMD_TIMED_CHECKIN, 2'h0, 8'h00, 8'h00);
		p = pkt_count;
		wait_for(1, 200, n);
		check("wait_span", 16'h0001, 16'(n >= 2 * SLOT));
		check("pkt_count", 16'(p + 2), 16'(pkt_count));
		$display("test timed_wake done");

		ready_delay = 4'h0;
		cfg_write(swc_pkg::ADDR_PIN_MASK, 8'h81);
		cfg_write(swc_pkg::ADDR_SLEEP_HIGH, 8'h01);
		wait_for(0, 9000, n);
		wait_for(1, 200, n);
		port_b_pins[1] = 1'b1;
		no_tx(10);
		pin_is_input[7] = 1'b0;
		watch_pin_seven = 1'b1;
		no_tx(10);
		watch_pin_seven = 1'b0;
		@(negedge clk);
		pin_is_input[7] = 1'b1;
		no_tx(5);
		reply_en = 1'b1;
		watch_pin_seven = 1'b1;
		wait_for(0, 5, n);
		chk_pkt(swc_pkg::CMD_PIN_CHECKIN, 2'h2, 8'h80, 8'h80);
		wait_for(1, SLOT - 4, n);
		watch_pin_seven = 1'b0;
		wait_for(0, 5, n);
		chk_pkt(swc_pkg::CMD_PIN_CHECKIN, 2'h2, 8'h00, 8'h80);
		wait_for(1, SLOT - 4, n);
		$display("test pin_wake done");

		cfg_write(swc_pkg::ADDR_PIN_MASK, 8'h20);
		reply_cmd = 8'h55;
		port_a_pins[2] = 1'b1;
		wait_for(0, 5, n);
		chk_pkt(swc_pkg::CMD_PIN_CHECKIN, 2'h2, 8'h20, 8'h20);
		repeat (3 * SLOT) @(negedge clk);
		check("radio_hibernate", 16'h0000, 16'(radio_hibernate));
		reply_cmd = 8'ha4;
		port_a_pins[2] = 1'b0;
		wait_for(0, 5, n);
		chk_pkt(swc_pkg::CMD_PIN_CHECKIN, 2'h2, 8'h00, 8'h20);
		wait_for(1, SLOT - 4, n);
		$display("test pin_map_and_run done");

		low_power_strap_pin = 1'b1;
		reset = 1'b1;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		no_tx(3 * UNIT);
		check("radio_hibernate", 16'h0000, 16'(radio_hibernate));
		check("cpu_stop", 16'h0000, 16'(cpu_stop));
		$display("test awake_boot done");

		reserved_mode_strap_pin = 1'b0;
		reset = 1'b1;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		check("reserved_mode", 16'h0001, 16'(reserved_mode));
		no_tx(4 * UNIT);
		// Outside logic must not keep this strap low, so it goes back high at once.
		reserved_mode_strap_pin = 1'b1;
		$display("test reserved_mode done");
		finish_test();
	end
endmodule : tb_sleep_wake_controller
